// ---- verilog/srs_pkg.sv ----
// constants and types for the shift, rotate and subtract datapath
package srs_pkg;
    // ==========================================================
    // word and field sizes
    localparam int unsigned DATA_W = 32;
    localparam int unsigned ADDR_W = 9;
    localparam int unsigned CNT_W = 5;
    localparam int unsigned OP_W = 6;
    localparam int unsigned COND_W = 4;
    localparam int unsigned MEM_DEPTH = 512;
    // ==========================================================
    // field positions inside the instruction word
    localparam int unsigned F_OP_LSB = 26;
    localparam int unsigned F_ZW = 25;
    localparam int unsigned F_CW = 24;
    localparam int unsigned F_RW = 23;
    localparam int unsigned F_IMM = 22;
    localparam int unsigned F_COND_LSB = 18;
    localparam int unsigned F_DST_LSB = 9;
    localparam int unsigned F_SRC_LSB = 0;
    localparam int unsigned MSB = 31;
    // ==========================================================
    // opcodes
    localparam logic [5:0] OP_ROTATE_RIGHT = 6'h08;
    localparam logic [5:0] OP_ROTATE_LEFT = 6'h09;
    localparam logic [5:0] OP_SHIFT_RIGHT = 6'h0A;
    localparam logic [5:0] OP_SHIFT_LEFT = 6'h0B;
    localparam logic [5:0] OP_SHIFT_ARITH_RIGHT = 6'h0E;
    localparam logic [5:0] OP_BIT_MIRROR_LOW = 6'h0F;
    localparam logic [5:0] OP_JUMP_BRANCH = 6'h17;
    localparam logic [5:0] OP_SUB = 6'h21;
    // ==========================================================
    // reset values and timing
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
    localparam logic [8:0] PC_RESET = 9'h000;
    localparam logic [8:0] PC_STEP = 9'h001;
    localparam int unsigned INSTR_CLOCKS = 4;
    // ==========================================================
    // sequencer states, gray along the path
    typedef enum logic [1:0]
    {
        ST_IDLE = 2'b00,
        ST_READ = 2'b01,
        ST_EXEC = 2'b11,
        ST_WB = 2'b10
    } srs_state_t;
endpackage

// ---- verilog/srs_mirror.sv ----
// bit mirror of the low bits with zero extension
`timescale 1ns/1ns
module srs_mirror
#(
    parameter int unsigned WIDTH = srs_pkg::DATA_W,
    parameter int unsigned CW = srs_pkg::CNT_W
)
(
    // operands
    input wire logic [WIDTH-1:0] value_i,
    input wire logic [CW-1:0] count_i,
    // result
    output logic [WIDTH-1:0] mirror_o
);
    import srs_pkg::*;
    // ==========================================================
    // full reversal, then drop count bits off the bottom
    logic [WIDTH-1:0] rev_all;
    genvar g;
    generate
        for (g = 0; g < WIDTH; g = g + 1)
        begin : g_rev
            assign rev_all[g] = value_i[WIDTH-1-g];
        end
    endgenerate
    assign mirror_o = rev_all >> count_i;
endmodule // srs_mirror

// ---- verilog/srs_alu.sv ----
// four-clock shift, rotate, subtract and jump execution unit
`timescale 1ns/1ns
module srs_alu
#(
    parameter int unsigned DEPTH = srs_pkg::MEM_DEPTH
)
(
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    // instruction issue
    input wire logic instr_valid_i,
    input wire logic [srs_pkg::DATA_W-1:0] instr_i,
    output logic ready_o,
    // register preload port, idle only
    input wire logic load_we_i,
    input wire logic [srs_pkg::ADDR_W-1:0] load_addr_i,
    input wire logic [srs_pkg::DATA_W-1:0] load_data_i,
    // register peek port
    input wire logic [srs_pkg::ADDR_W-1:0] peek_addr_i,
    output logic [srs_pkg::DATA_W-1:0] peek_data_o,
    // completion and writeback
    output logic done_o,
    output logic wr_en_o,
    output logic [srs_pkg::ADDR_W-1:0] wr_addr_o,
    output logic [srs_pkg::DATA_W-1:0] result_o,
    // flags and program counter
    output logic z_o,
    output logic c_o,
    output logic [srs_pkg::ADDR_W-1:0] pc_o
);
    import srs_pkg::*;

    // ==========================================================
    // state
    srs_state_t state_reg; // sequencer state
    srs_state_t state_next; // next sequencer state
    logic [DATA_W-1:0] instr_reg; // latched instruction
    logic [DATA_W-1:0] d_val_reg; // destination operand
    logic [DATA_W-1:0] s_val_reg; // source operand
    logic [DATA_W-1:0] res_reg; // computed result
    logic cout_reg; // computed carry
    logic z_reg; // zero flag
    logic c_reg; // carry flag
    logic [ADDR_W-1:0] pc_reg; // program counter
    logic done_reg; // completion pulse
    logic fin_exec_reg; // finished word really executed
    logic wr_en_reg; // writeback pulse
    logic [ADDR_W-1:0] wr_addr_reg; // writeback address
    logic [DATA_W-1:0] peek_reg; // peek data
    logic [DATA_W-1:0] mem [0:DEPTH-1]; // register file

    // ==========================================================
    // field decode
    wire [OP_W-1:0] op_w = instr_reg[F_OP_LSB +: OP_W];
    wire zw_w = instr_reg[F_ZW]; // zero write effect
    wire cw_w = instr_reg[F_CW]; // carry write effect
    wire rw_w = instr_reg[F_RW]; // result write effect
    wire imm_w = instr_reg[F_IMM]; // immediate select
    wire [COND_W-1:0] cond_w = instr_reg[F_COND_LSB +: COND_W];
    wire [ADDR_W-1:0] dst_w = instr_reg[F_DST_LSB +: ADDR_W];
    wire [ADDR_W-1:0] src_w = instr_reg[F_SRC_LSB +: ADDR_W];

    // opcode known to this unit
    function automatic logic op_known(input logic [OP_W-1:0] op);
        op_known = (op == OP_ROTATE_LEFT) || (op == OP_ROTATE_RIGHT)
                || (op == OP_SHIFT_LEFT) || (op == OP_SHIFT_RIGHT)
                || (op == OP_SHIFT_ARITH_RIGHT) || (op == OP_BIT_MIRROR_LOW)
                || (op == OP_SUB) || (op == OP_JUMP_BRANCH);
    endfunction

    // ==========================================================
    // datapath
    wire [CNT_W-1:0] cnt_w = s_val_reg[CNT_W-1:0]; // shift count
    wire [2*DATA_W-1:0] dbl_w = {d_val_reg, d_val_reg};
    wire [2*DATA_W-1:0] rol_dbl_w = dbl_w << cnt_w;
    wire [2*DATA_W-1:0] ror_dbl_w = dbl_w >> cnt_w;
    wire [DATA_W-1:0] mirror_w;
    wire [DATA_W:0] diff_w = {1'b0, d_val_reg} - {1'b0, s_val_reg};
    wire [ADDR_W-1:0] pc_inc_w = pc_reg + PC_STEP;
    wire [DATA_W-1:0] sar_w = DATA_W'($signed(d_val_reg) >>> cnt_w);
    logic [DATA_W-1:0] alu_res; // combinational result
    logic alu_c; // combinational carry
    // condition field indexed by current flags
    wire cond_ok_w = cond_w[{c_reg, z_reg}];
    wire exec_w = cond_ok_w && op_known(op_w);
    wire is_jump_w = (op_w == OP_JUMP_BRANCH);

    srs_mirror #(.WIDTH(DATA_W), .CW(CNT_W)) u_mirror
    (
        .value_i(d_val_reg),
        .count_i(cnt_w),
        .mirror_o(mirror_w)
    );

    // result and carry selection
    always_comb
    begin
        alu_res = d_val_reg;
        alu_c = c_reg;
        case (op_w)
            OP_ROTATE_LEFT:
            begin
                alu_res = rol_dbl_w[2*DATA_W-1:DATA_W];
                alu_c = d_val_reg[MSB];
            end
            OP_ROTATE_RIGHT:
            begin
                alu_res = ror_dbl_w[DATA_W-1:0];
                alu_c = d_val_reg[0];
            end
            OP_SHIFT_ARITH_RIGHT:
            begin
                alu_res = sar_w;
                alu_c = d_val_reg[0];
            end
            OP_SHIFT_LEFT:
            begin
                alu_res = d_val_reg << cnt_w;
                alu_c = d_val_reg[MSB];
            end
            OP_SHIFT_RIGHT:
            begin
                alu_res = d_val_reg >> cnt_w;
                alu_c = d_val_reg[0];
            end
            OP_BIT_MIRROR_LOW:
            begin
                alu_res = mirror_w;
                alu_c = d_val_reg[0];
            end
            OP_SUB:
            begin
                alu_res = diff_w[DATA_W-1:0];
                alu_c = diff_w[DATA_W];
            end
            // return address as the jump's own result
            OP_JUMP_BRANCH:
            begin
                alu_res = {{(DATA_W-ADDR_W){1'b0}}, pc_inc_w};
                alu_c = c_reg;
            end
            default:
            begin
                alu_res = d_val_reg;
                alu_c = c_reg;
            end
        endcase
    end

    // ==========================================================
    // sequencer
    // four clocks per instruction
    always_comb
    begin
        case (state_reg)
            ST_IDLE: state_next = instr_valid_i ? ST_READ : ST_IDLE;
            ST_READ: state_next = ST_EXEC;
            ST_EXEC: state_next = ST_WB;
            ST_WB: state_next = ST_IDLE;
            default: state_next = ST_IDLE;
        endcase
    end

    assign ready_o = (state_reg == ST_IDLE);

    // state and instruction latch
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
        begin
            state_reg <= ST_IDLE;
            instr_reg <= ZERO_WORD;
        end
        else
        begin
            state_reg <= state_next;
            if (ready_o && instr_valid_i)
                instr_reg <= instr_i;
        end
    end

    // operand fetch and execute
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
        begin
            d_val_reg <= ZERO_WORD;
            s_val_reg <= ZERO_WORD;
            res_reg <= ZERO_WORD;
            cout_reg <= 1'b0;
        end
        else if (state_reg == ST_READ)
        begin
            d_val_reg <= mem[dst_w];
            s_val_reg <= imm_w ? {{(DATA_W-ADDR_W){1'b0}}, src_w} : mem[src_w];
        end
        else if (state_reg == ST_EXEC)
        begin
            res_reg <= alu_res;
            cout_reg <= alu_c;
        end
    end

    // register file write: writeback wins over preload
    always_ff @(posedge ref_clk_i)
    begin
        // write only with result effect, never for jump
        if (state_reg == ST_WB && exec_w && rw_w && !is_jump_w)
            mem[dst_w] <= res_reg;
        else if (ready_o && load_we_i)
            mem[load_addr_i] <= load_data_i;
        peek_reg <= mem[peek_addr_i];
    end

    // flags, program counter and writeback report
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
        begin
            z_reg <= 1'b0;
            c_reg <= 1'b0;
            pc_reg <= PC_RESET;
            done_reg <= 1'b0;
            fin_exec_reg <= 1'b0;
            wr_en_reg <= 1'b0;
            wr_addr_reg <= PC_RESET;
            result_o <= ZERO_WORD;
        end
        else
        begin
            done_reg <= (state_reg == ST_WB);
            fin_exec_reg <= (state_reg == ST_WB) && exec_w;
            wr_en_reg <= (state_reg == ST_WB) && exec_w && rw_w && !is_jump_w;
            if (state_reg == ST_WB)
            begin
                wr_addr_reg <= dst_w;
                result_o <= res_reg;
                if (exec_w && zw_w)
                    z_reg <= (res_reg == ZERO_WORD);
                if (exec_w && cw_w)
                    c_reg <= cout_reg;
                // jump loads the source as new pc
                if (exec_w && is_jump_w)
                    pc_reg <= s_val_reg[ADDR_W-1:0];
                else
                    pc_reg <= pc_inc_w;
            end
        end
    end

    assign done_o = done_reg;
    assign wr_en_o = wr_en_reg;
    assign wr_addr_o = wr_addr_reg;
    assign z_o = z_reg;
    assign c_o = c_reg;
    assign pc_o = pc_reg;
    assign peek_data_o = peek_reg;

    // ==========================================================
    // assertions
    wire accept_w = ready_o && instr_valid_i;
    wire fin_w = done_reg; // results visible this cycle
    wire [OP_W-1:0] fin_op_w = op_w;

    sequence s_busy3;
        !ready_o [*3];
    endsequence
    sequence s_issue;
        accept_w ##1 s_busy3;
    endsequence

    a_four_clocks: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        s_issue |=> ready_o && done_o)
        else $error("instruction did not finish in four clocks");
    a_rol_carry: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        fin_w && fin_op_w == OP_ROTATE_LEFT && cw_w && fin_exec_reg
        |-> c_o == d_val_reg[MSB])
        else $error("rotate left carry wrong");
    a_ror_value: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        fin_w && fin_op_w == OP_ROTATE_RIGHT
        |-> result_o == ((d_val_reg >> cnt_w) | (d_val_reg << (DATA_W - cnt_w))))
        else $error("rotate right value wrong");
    a_sar_sign: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        fin_w && fin_op_w == OP_SHIFT_ARITH_RIGHT |-> result_o[MSB] == d_val_reg[MSB])
        else $error("arithmetic shift lost the sign");
    a_shl_low: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        fin_w && fin_op_w == OP_SHIFT_LEFT && cnt_w != 0 |-> result_o[0] == 1'b0)
        else $error("shift left did not fill zero");
    a_shr_high: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        fin_w && fin_op_w == OP_SHIFT_RIGHT && cnt_w != 0 |-> result_o[MSB] == 1'b0)
        else $error("shift right did not fill zero");
    a_mirror_bit: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        fin_w && fin_op_w == OP_BIT_MIRROR_LOW
        |-> result_o[MSB - cnt_w] == d_val_reg[0])
        else $error("mirror misplaced bit zero");
    a_sub_borrow: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        fin_w && fin_op_w == OP_SUB && cw_w && fin_exec_reg
        |-> c_o == (d_val_reg < s_val_reg))
        else $error("subtract borrow wrong");
    a_zero_flag: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        fin_w && zw_w && fin_exec_reg |-> z_o == (result_o == ZERO_WORD))
        else $error("zero flag does not match result");
    a_carry_hold: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (state_reg != ST_WB || !cw_w) |=> $stable(c_o))
        else $error("carry changed without carry write");
    a_no_write: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        fin_w && (!rw_w || is_jump_w) |-> !wr_en_o)
        else $error("result written while suppressed");
    a_imm_operand: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        state_reg == ST_EXEC && imm_w |-> s_val_reg == {{(DATA_W-ADDR_W){1'b0}}, src_w})
        else $error("immediate operand not taken");
endmodule // srs_alu

// ---- dv/srs_alu_tb.sv ----
// self-checking bench for the shift, rotate and subtract unit
`timescale 1ns/1ns
module srs_alu_tb;
    import srs_pkg::*;
    // ==========================================================
    // table row: opcode, immediate source, destination, result, carry
    typedef struct packed
    {
        logic [5:0] op;
        logic [8:0] src;
        logic [31:0] d;
        logic [31:0] res;
        logic c;
    } srs_row_t;
    // ==========================================================
    // bench signals
    logic ref_clk;
    logic rst_n;
    logic instr_valid;
    logic [31:0] instr;
    logic load_we;
    logic [8:0] load_addr;
    logic [31:0] load_data;
    logic [8:0] peek_addr;
    logic ready, done, wr_en, z, c;
    logic [31:0] peek_data, result;
    logic [8:0] wr_addr, pc;
    // counters and expected program counter
    int n_mismatch = 0;
    int n_compared = 0;
    int cycles = 0;
    int k;
    logic [8:0] exp_pc = 9'h000;
    // ordinary cases, all effects on, immediate count or subtrahend
    srs_row_t rows [14] = '{
        '{OP_ROTATE_LEFT, 9'h004, 32'h8000_0003, 32'h0000_0038, 1'h1},
        '{OP_ROTATE_LEFT, 9'h000, 32'h1234_5678, 32'h1234_5678, 1'h0},
        '{OP_ROTATE_RIGHT, 9'h004, 32'h8000_0003, 32'h3800_0000, 1'h1},
        '{OP_SHIFT_ARITH_RIGHT, 9'h004, 32'h8000_0003, 32'hF800_0000, 1'h1},
        '{OP_SHIFT_ARITH_RIGHT, 9'h008, 32'h7F00_0000, 32'h007F_0000, 1'h0},
        '{OP_SHIFT_LEFT, 9'h004, 32'h8000_0003, 32'h0000_0030, 1'h1},
        '{OP_SHIFT_LEFT, 9'h001, 32'h8000_0000, 32'h0000_0000, 1'h1},
        '{OP_SHIFT_RIGHT, 9'h004, 32'h8000_0003, 32'h0800_0000, 1'h1},
        '{OP_SHIFT_RIGHT, 9'h01F, 32'hFFFF_FFFE, 32'h0000_0001, 1'h0},
        '{OP_BIT_MIRROR_LOW, 9'h01C, 32'h8000_0003, 32'h0000_000C, 1'h1},
        '{OP_BIT_MIRROR_LOW, 9'h000, 32'h0000_0001, 32'h8000_0000, 1'h1},
        '{OP_SUB, 9'h1FF, 32'h8000_0003, 32'h7FFF_FE04, 1'h0},
        '{OP_SUB, 9'h004, 32'h0000_0003, 32'hFFFF_FFFF, 1'h1},
        '{OP_SUB, 9'h005, 32'h0000_0005, 32'h0000_0000, 1'h0}
    };
    // ==========================================================
    // unit under test
    srs_alu dut
    (
        .ref_clk_i(ref_clk),
        .rst_n_i(rst_n),
        .instr_valid_i(instr_valid),
        .instr_i(instr),
        .ready_o(ready),
        .load_we_i(load_we),
        .load_addr_i(load_addr),
        .load_data_i(load_data),
        .peek_addr_i(peek_addr),
        .peek_data_o(peek_data),
        .done_o(done),
        .wr_en_o(wr_en),
        .wr_addr_o(wr_addr),
        .result_o(result),
        .z_o(z),
        .c_o(c),
        .pc_o(pc)
    );
    // ==========================================================
    // clock, 8 ns period
    initial
    begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    // hang guard, far above the expected run length
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            n_mismatch++;
            stop_test();
        end
    end
    // ==========================================================
    // compare tasks
    task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_bit(input string nm, input logic e, input logic g);
        n_compared++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("MISMATCH %s expected %b seen %b", nm, e, g);
        end
    endtask
    // ==========================================================
    // drivers
    function automatic logic [31:0] iw(input logic [5:0] op, input logic [3:0] zcri,
        input logic [8:0] d, input logic [8:0] s);
        return {op, zcri, 4'hF, d, s};
    endfunction
    // preload one register while idle
    task automatic load(input logic [8:0] a, input logic [31:0] v);
        @(posedge ref_clk);
        load_we <= 1'b1;
        load_addr <= a;
        load_data <= v;
        @(posedge ref_clk);
        load_we <= 1'b0;
    endtask
    // registered read, data one clock after the address
    task automatic peek(input logic [8:0] a, input logic [31:0] e);
        @(posedge ref_clk);
        peek_addr <= a;
        repeat (2) @(posedge ref_clk);
        #1 chk_word("peek", e, peek_data);
    endtask
    // issue one word, wait for done, check latency and program counter
    task automatic run(input logic [31:0] w);
        @(posedge ref_clk);
        instr_valid <= 1'b1;
        instr <= w;
        @(posedge ref_clk);
        instr_valid <= 1'b0;
        // the accepting edge is the first of the four clocks
        k = 1;
        do
        begin
            @(posedge ref_clk);
            #1 k++;
        end
        while (done !== 1'b1 && k < 10);
        chk_word("latency", INSTR_CLOCKS, k);
        exp_pc = (w[31:26] == OP_JUMP_BRANCH) ? w[8:0] : exp_pc + PC_STEP;
        chk_word("pc", {23'h0, exp_pc}, {23'h0, pc});
    endtask
    // verdict and end of run
    task automatic stop_test();
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // ==========================================================
    // main sequence
    initial
    begin
        rst_n = 1'b0;
        instr_valid = 1'b0;
        instr = 32'h0000_0000;
        load_we = 1'b0;
        load_addr = 9'h000;
        load_data = 32'h0000_0000;
        peek_addr = 9'h000;
        repeat (20) @(posedge ref_clk);
        rst_n <= 1'b1;
        #1;
        // reset values
        chk_bit("ready", 1'b1, ready);
        chk_bit("done", 1'b0, done);
        chk_bit("z", 1'b0, z);
        chk_bit("c", 1'b0, c);
        chk_word("pc", 32'h0000_0000, {23'h0, pc});
        chk_word("result", 32'h0000_0000, result);
        chk_word("wr_addr", 32'h0000_0000, {23'h0, wr_addr});
        $display("reset test done");
        // table rows: every operation code except jump
        for (int i = 0; i < 14; i++)
        begin
            load(9'h005, rows[i].d);
            run(iw(rows[i].op, 4'hF, 9'h005, rows[i].src));
            chk_word("result", rows[i].res, result);
            chk_bit("z", rows[i].res == 32'h0, z);
            chk_bit("c", rows[i].c, c);
            chk_bit("wr_en", 1'b1, wr_en);
            chk_word("wr_addr", 32'h0000_0005, {23'h0, wr_addr});
            peek(9'h005, rows[i].res);
            $display("row %0d done", i);
        end
        // flags hold when their effects are off (z=1, c=0 from the last row)
        load(9'h005, 32'h0000_0001);
        run(iw(OP_SHIFT_LEFT, 4'h3, 9'h005, 9'h001));
        chk_word("result", 32'h0000_0002, result);
        chk_bit("z", 1'b1, z);
        chk_bit("c", 1'b0, c);
        load(9'h005, 32'h8000_0000);
        run(iw(OP_SHIFT_LEFT, 4'hF, 9'h005, 9'h001));
        run(iw(OP_SHIFT_LEFT, 4'h3, 9'h005, 9'h001));
        chk_bit("z", 1'b1, z);
        chk_bit("c", 1'b1, c);
        $display("flag hold test done");
        // result suppressed, flags still written
        load(9'h005, 32'h0000_0003);
        run(iw(OP_SUB, 4'hD, 9'h005, 9'h004));
        chk_word("result", 32'hFFFF_FFFF, result);
        chk_bit("c", 1'b1, c);
        chk_bit("z", 1'b0, z);
        chk_bit("wr_en", 1'b0, wr_en);
        peek(9'h005, 32'h0000_0003);
        $display("no result test done");
        // register operands instead of literals
        load(9'h006, 32'h0000_0024);
        load(9'h005, 32'h0000_0003);
        run(iw(OP_SHIFT_LEFT, 4'h6, 9'h005, 9'h006));
        chk_word("result", 32'h0000_0030, result);
        chk_bit("c", 1'b0, c);
        load(9'h007, 32'h0000_1000);
        load(9'h005, 32'h0000_0020);
        run(iw(OP_SUB, 4'h6, 9'h005, 9'h007));
        chk_word("result", 32'hFFFF_F020, result);
        chk_bit("c", 1'b1, c);
        peek(9'h005, 32'hFFFF_F020);
        $display("register source test done");
        // routine exit: jump, no register written
        load(9'h005, 32'h0000_00A5);
        run(iw(OP_JUMP_BRANCH, 4'h1, 9'h005, 9'h040));
        chk_bit("wr_en", 1'b0, wr_en);
        peek(9'h005, 32'h0000_00A5);
        $display("jump test done");
        // false condition field: nothing written, flags kept, pc still steps
        load(9'h005, 32'h0000_0001);
        run(iw(OP_SHIFT_RIGHT, 4'hF, 9'h005, 9'h001) & 32'hFFC3_FFFF);
        chk_bit("wr_en", 1'b0, wr_en);
        chk_bit("z", 1'b0, z);
        peek(9'h005, 32'h0000_0001);
        $display("false condition test done");
        // reset in mid-run clears carry and program counter
        @(posedge ref_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        #1;
        chk_bit("c", 1'b0, c);
        chk_bit("ready", 1'b1, ready);
        chk_word("pc", 32'h0000_0000, {23'h0, pc});
        $display("mid-run reset test done");
        stop_test();
    end
endmodule // srs_alu_tb
